// >>> rtl/wtvs_pkg.sv
// Constants and encodings for the waveform trigger and vertical scale block
package wtvs_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TIMEOUT_MS = 100;
    localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int EXT_PW_US = 1;
    localparam int EXT_PW_CYC = (CLK_HZ / 1_000_000) * EXT_PW_US;
    localparam int NCH = 8;
    localparam int SW = 18;
    localparam int PW = 18;
    localparam int LW = 11;
    localparam int ZW = 5;
    localparam int CHW = ZW + PW;
    localparam int TW = 23;
    // Sample code that equals one measurement range, after scaling
    localparam int RANGE_CODE = 8192;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [2:0] ADDR_CH_TAG = 3'h2;
    localparam int CTRL_MODE_B = 0;
    localparam int CTRL_SLOPE_B = 1;
    localparam int CTRL_SRC_B = 3;
    localparam int CTRL_CF6_B = 7;
    localparam int CH_ZOOM_B = 0;
    localparam int CH_POS_B = 8;

    localparam logic [1:0] SLOPE_RISE = 2'h0;
    localparam logic [1:0] SLOPE_FALL = 2'h1;
    localparam logic [1:0] SLOPE_BOTH = 2'h2;
    localparam logic [3:0] SRC_EXT = 4'h8;

    localparam logic RST_MODE_NORM = 1'b0;
    localparam logic [1:0] RST_SLOPE = SLOPE_RISE;
    localparam logic [3:0] RST_SRC = 4'h0;
    localparam logic RST_CF6 = 1'b0;
    localparam logic signed [LW-1:0] RST_LEVEL = 11'sh000;
    localparam logic [ZW-1:0] RST_ZOOM = 5'h07;
    localparam logic signed [PW-1:0] RST_POS = 18'sh00000;

    localparam logic signed [15:0] LEVEL_MAX = 16'sd1000;
    localparam logic signed [PW-1:0] POS_MAX = 18'sd130000;
    // Level in 0.1 % steps to sample code, Q10 multiplier
    localparam logic [15:0] LVL_K3 = 16'(3 * RANGE_CODE * 1024 / 1000);
    localparam logic [15:0] LVL_K6 = 16'(6 * RANGE_CODE * 1024 / 1000);
    // Position in 0.001 % steps to sample code, Q16 multiplier
    localparam logic [15:0] POS_K3 = 16'(64'd3 * RANGE_CODE * 65536 / 100000);
    localparam logic [15:0] POS_K6 = 16'(64'd6 * RANGE_CODE * 65536 / 100000);
    localparam logic signed [SW-1:0] HYST3 = SW'(3 * RANGE_CODE * 2 / 100);
    localparam logic signed [SW-1:0] HYST6 = SW'(6 * RANGE_CODE * 4 / 100);

    // Zoom factors in Q8.8, index 7 is unity
    localparam logic [15:0] ZOOM_Q [32] = '{
        16'h001a, 16'h0033, 16'h0040, 16'h0066, 16'h0080, 16'h00c0, 16'h00cd, 16'h0100,
        16'h0124, 16'h0140, 16'h0154, 16'h0169, 16'h0180, 16'h019a, 16'h01c5, 16'h0200,
        16'h0248, 16'h02a9, 16'h02d4, 16'h0333, 16'h038a, 16'h0400, 16'h0500, 16'h0800,
        16'h0a00, 16'h0c80, 16'h1000, 16'h1400, 16'h1900, 16'h2800, 16'h3200, 16'h6400};

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} wtvs_state_t;
endpackage : wtvs_pkg

// >>> rtl/wtvs_chmem.sv
// Per-channel zoom and position store with registered read ports
`timescale 1ns/1ns
module wtvs_chmem (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_we,
    input wire logic [2:0] i_waddr,
    input wire logic [wtvs_pkg::CHW-1:0] i_wdata,
    input wire logic i_rd_a,
    input wire logic i_sel_a,
    input wire logic [2:0] i_raddr_a,
    input wire logic [31:0] i_bypass_a,
    output logic [31:0] o_rdata_a,
    input wire logic [2:0] i_raddr_b,
    output logic [wtvs_pkg::CHW-1:0] o_rdata_b
);
    import wtvs_pkg::*;

    typedef struct packed {
        logic [NCH-1:0][CHW-1:0] mem;
        logic [31:0] rda;
        logic [CHW-1:0] rdb;
    } wtvs_mem_t;

    wtvs_mem_t s_r;
    wtvs_mem_t s_nxt;
    logic [CHW-1:0] ent_a;

    always_comb begin
        s_nxt = s_r;
        ent_a = s_r.mem[i_raddr_a];
        if (i_we) begin
            s_nxt.mem[i_waddr] = i_wdata;
        end
        // Bus port answers only in the cycle after a read
        s_nxt.rda = 32'h0;
        if (i_rd_a && i_sel_a) begin
            s_nxt.rda = {6'h00, ent_a[PW-1:0], 3'h0, ent_a[CHW-1:PW]};
        end else if (i_rd_a) begin
            s_nxt.rda = i_bypass_a;
        end
        s_nxt.rdb = s_r.mem[i_raddr_b];
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            s_r <= '0;
            for (int k = 0; k < NCH; k++) begin
                s_r.mem[k] <= {RST_ZOOM, RST_POS};
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata_a = s_r.rda;
    assign o_rdata_b = s_r.rdb;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    pos_in_range_a: assert property (
        $signed(o_rdata_b[PW-1:0]) <= POS_MAX && $signed(o_rdata_b[PW-1:0]) >= -POS_MAX)
        else $error("stored position beyond 130 percent");
endmodule : wtvs_chmem

// >>> rtl/wtvs_top.sv
// Trigger detection, display update control and vertical scaling for the waveform view
// How it works
// - Auto mode: trigger before timeout aligns update
// - Auto mode: timeout forces an unaligned update
// - Normal mode: update only on a trigger, except on interval ticks while integration runs
// - Source from installed channels or external input
// - External source ignores the trigger level
// - External edge seen within one microsecond
// - Rising slope: crossing upward through level
// - Falling slope: crossing downward through level
// - Both slopes: crossing in either direction
// - Level is signed, at most 100 percent
// - Full scale is three or six ranges
// - Crest factor three uses two percent hysteresis
// - Crest factor six uses four percent hysteresis
// - Integration running: no trigger, free updates
// - Per-channel zoom from thirty-two fixed factors
// - Per-channel position, at most 130 percent
// - Unity zoom: half span is full scale
// - Other zooms keep position on full scale
`timescale 1ns/1ns
module wtvs_top #(
    parameter int TIMEOUT_CYCLES = wtvs_pkg::TIMEOUT_CYC
) (
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic [3:0] I_ELEM_PRESENT,
    input wire logic I_INTEG_ACTIVE,
    input wire logic I_INTERVAL_TICK,
    input wire logic I_SAMPLE_VALID,
    input wire logic [wtvs_pkg::NCH*wtvs_pkg::SW-1:0] I_SAMPLE_DATA,
    input wire logic I_EXT_CLK,
    input wire logic [2:0] I_VIEW_CH,
    output logic O_TRIG,
    output logic O_UPDATE,
    output logic O_ALIGNED,
    output logic [15:0] O_VZOOM,
    output logic signed [wtvs_pkg::SW-1:0] O_VOFFSET
);
    import wtvs_pkg::*;

    localparam logic [TW-1:0] TO_LAST = TW'(TIMEOUT_CYCLES - 1);
    // Half an output step, so the offset rounds to the nearest code instead of down
    localparam logic signed [PW+16:0] POS_RND = (PW+17)'(16'h8000);

    typedef struct packed {
        logic mode_norm;
        logic [1:0] slope;
        logic [3:0] src;
        logic cf6;
        logic signed [LW-1:0] level;
        wtvs_state_t st;
        logic [TW-1:0] timer;
        logic arm_r;
        logic arm_f;
        logic ext_q;
        logic trig;
        logic upd;
        logic aligned;
        logic last_al;
        logic [15:0] vzoom;
        logic signed [SW-1:0] voff;
    } wtvs_main_t;

    wtvs_main_t s_r;
    wtvs_main_t s_nxt;

    logic signed [SW-1:0] samp [NCH];
    logic signed [SW-1:0] x;
    logic signed [SW-1:0] lvl_cnt;
    logic signed [SW-1:0] hyst;
    logic signed [LW+16:0] lvl_prod;
    logic signed [PW+16:0] pos_prod;
    logic hit_r;
    logic hit_f;
    logic det;
    logic ch_hit;
    logic [CHW-1:0] mem_b;
    logic [31:0] bypass;
    logic [CHW-1:0] mem_wdata;

    for (genvar g = 0; g < NCH; g++) begin : g_unpack
        assign samp[g] = I_SAMPLE_DATA[g*SW +: SW];
    end

    function automatic logic src_ok(input logic [3:0] v, input logic [3:0] present);
        if (v == SRC_EXT) begin
            return 1'b1;
        end
        return !v[3] && present[v[2:1]];
    endfunction : src_ok

    function automatic logic signed [LW-1:0] clamp_lvl(input logic signed [15:0] v);
        if (v > LEVEL_MAX) begin
            return LW'(LEVEL_MAX);
        end
        if (v < -LEVEL_MAX) begin
            return LW'(-LEVEL_MAX);
        end
        return LW'(v);
    endfunction : clamp_lvl

    function automatic logic signed [PW-1:0] clamp_pos(input logic signed [PW-1:0] v);
        if (v > POS_MAX) begin
            return POS_MAX;
        end
        if (v < -POS_MAX) begin
            return -POS_MAX;
        end
        return v;
    endfunction : clamp_pos

    assign ch_hit = (I_ADDR[7:5] == ADDR_CH_TAG) && (I_ADDR[1:0] == 2'h0);
    assign mem_wdata = {I_WDATA[CH_ZOOM_B +: ZW], clamp_pos(I_WDATA[CH_POS_B +: PW])};

    always_comb begin
        bypass = 32'h0;
        case (I_ADDR)
            ADDR_CTRL: begin
                bypass[CTRL_MODE_B] = s_r.mode_norm;
                bypass[CTRL_SLOPE_B +: 2] = s_r.slope;
                bypass[CTRL_SRC_B +: 4] = s_r.src;
                bypass[CTRL_CF6_B] = s_r.cf6;
            end
            ADDR_LEVEL: begin
                bypass = 32'(s_r.level);
            end
            ADDR_STATUS: begin
                bypass[0] = (s_r.st == ST_WAIT);
                bypass[1] = s_r.last_al;
                bypass[2] = I_INTEG_ACTIVE;
                bypass[7:4] = I_ELEM_PRESENT;
            end
            default: begin
                bypass = 32'h0;
            end
        endcase
    end

    wtvs_chmem u_chmem (
        .i_clock(I_CLOCK),
        .i_srst(I_SRST),
        .i_we(I_WR && ch_hit),
        .i_waddr(I_ADDR[4:2]),
        .i_wdata(mem_wdata),
        .i_rd_a(I_RD),
        .i_sel_a(ch_hit),
        .i_raddr_a(I_ADDR[4:2]),
        .i_bypass_a(bypass),
        .o_rdata_a(O_RDATA),
        .i_raddr_b(I_VIEW_CH),
        .o_rdata_b(mem_b)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.trig = 1'b0;
        s_nxt.upd = 1'b0;
        s_nxt.aligned = 1'b0;
        // Level to sample code at the active crest factor
        lvl_prod = s_r.level * $signed({1'b0, s_r.cf6 ? LVL_K6 : LVL_K3});
        lvl_cnt = SW'(lvl_prod >>> 10);
        hyst = s_r.cf6 ? HYST6 : HYST3;
        x = samp[s_r.src[2:0]];
        hit_r = 1'b0;
        hit_f = 1'b0;

        if (I_WR && I_ADDR == ADDR_CTRL) begin
            s_nxt.mode_norm = I_WDATA[CTRL_MODE_B];
            if (I_WDATA[CTRL_SLOPE_B +: 2] != 2'h3) begin
                s_nxt.slope = I_WDATA[CTRL_SLOPE_B +: 2];
            end
            if (src_ok(I_WDATA[CTRL_SRC_B +: 4], I_ELEM_PRESENT)) begin
                s_nxt.src = I_WDATA[CTRL_SRC_B +: 4];
            end
            s_nxt.cf6 = I_WDATA[CTRL_CF6_B];
            // Clears arming from the old source; a valid sample in the same cycle can still re-arm from it
            s_nxt.arm_r = 1'b0;
            s_nxt.arm_f = 1'b0;
        end
        if (I_WR && I_ADDR == ADDR_LEVEL) begin
            s_nxt.level = clamp_lvl(I_WDATA[15:0]);
        end

        s_nxt.ext_q = I_EXT_CLK;
        if (s_r.src == SRC_EXT) begin
            // Level plays no part; a single-cycle edge check relies on clean TTL pulses
            hit_r = I_EXT_CLK && !s_r.ext_q;
            hit_f = !I_EXT_CLK && s_r.ext_q;
        end else if (I_SAMPLE_VALID) begin
            hit_r = s_r.arm_r && (x > lvl_cnt);
            hit_f = s_r.arm_f && (x < lvl_cnt);
            if (x < lvl_cnt - hyst) begin
                s_nxt.arm_r = 1'b1;
            end else if (hit_r) begin
                s_nxt.arm_r = 1'b0;
            end
            if (x > lvl_cnt + hyst) begin
                s_nxt.arm_f = 1'b1;
            end else if (hit_f) begin
                s_nxt.arm_f = 1'b0;
            end
        end

        case (s_r.slope)
            SLOPE_RISE: det = hit_r;
            SLOPE_FALL: det = hit_f;
            SLOPE_BOTH: det = hit_r || hit_f;
            default: det = 1'b0;
        endcase
        det = det && !I_INTEG_ACTIVE;
        s_nxt.trig = det;

        case (s_r.st)
            ST_IDLE: begin
                if (I_INTERVAL_TICK && I_INTEG_ACTIVE) begin
                    s_nxt.upd = 1'b1;
                    s_nxt.last_al = 1'b0;
                end else if (I_INTERVAL_TICK) begin
                    s_nxt.st = ST_WAIT;
                    s_nxt.timer = '0;
                end
            end
            ST_WAIT: begin
                if (I_INTEG_ACTIVE) begin
                    s_nxt.st = ST_IDLE;
                end else if (det) begin
                    s_nxt.upd = 1'b1;
                    s_nxt.aligned = 1'b1;
                    s_nxt.last_al = 1'b1;
                    s_nxt.st = ST_IDLE;
                end else if (!s_r.mode_norm && s_r.timer >= TO_LAST) begin
                    s_nxt.upd = 1'b1;
                    s_nxt.last_al = 1'b0;
                    s_nxt.st = ST_IDLE;
                end else if (s_r.timer != '1) begin
                    // Saturates in normal mode, which may wait for ever
                    s_nxt.timer = s_r.timer + 1'b1;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // Offset stays tied to crest-factor full scale whatever the zoom
        s_nxt.vzoom = ZOOM_Q[mem_b[CHW-1:PW]];
        pos_prod = $signed(mem_b[PW-1:0]) * $signed({1'b0, s_r.cf6 ? POS_K6 : POS_K3});
        s_nxt.voff = SW'((pos_prod + POS_RND) >>> 16);
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            s_r <= '0;
            s_r.mode_norm <= RST_MODE_NORM;
            s_r.slope <= RST_SLOPE;
            s_r.src <= RST_SRC;
            s_r.cf6 <= RST_CF6;
            s_r.level <= RST_LEVEL;
            s_r.st <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign O_TRIG = s_r.trig;
    assign O_UPDATE = s_r.upd;
    assign O_ALIGNED = s_r.aligned;
    assign O_VZOOM = s_r.vzoom;
    assign O_VOFFSET = s_r.voff;

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SRST);

    trig_aligns_update_a: assert property (
        (s_r.st == ST_WAIT) && det |=> O_UPDATE && O_ALIGNED && O_TRIG)
        else $error("trigger while waiting gave no aligned update");

    auto_timeout_a: assert property (
        (s_r.st == ST_WAIT) && !s_r.mode_norm && !I_INTEG_ACTIVE && !det
        && (s_r.timer >= TO_LAST) |=> O_UPDATE && !O_ALIGNED)
        else $error("auto timeout gave no forced update");

    normal_needs_trig_a: assert property (
        O_UPDATE && $past(s_r.mode_norm) && !$past(I_INTEG_ACTIVE) |-> O_ALIGNED && O_TRIG)
        else $error("normal mode updated without trigger");

    bad_src_kept_a: assert property (
        I_WR && (I_ADDR == ADDR_CTRL)
        && !src_ok(I_WDATA[CTRL_SRC_B +: 4], I_ELEM_PRESENT) |=> $stable(s_r.src))
        else $error("absent source was accepted");

    ext_edge_fast_a: assert property (
        (s_r.src == SRC_EXT) && (s_r.slope != SLOPE_FALL) && !I_INTEG_ACTIVE
        && I_EXT_CLK && !s_r.ext_q |=> O_TRIG)
        else $error("external edge not seen in time");

    ext_no_level_a: assert property (
        O_TRIG && $past(s_r.src) == SRC_EXT |-> $past(I_EXT_CLK) != $past(s_r.ext_q))
        else $error("external trigger without an edge");

    rise_cross_a: assert property (
        O_TRIG && $past(s_r.slope) == SLOPE_RISE && $past(s_r.src) != SRC_EXT
        |-> $past(x > lvl_cnt) && $past(s_r.arm_r))
        else $error("rising trigger without upward crossing");

    fall_cross_a: assert property (
        O_TRIG && $past(s_r.slope) == SLOPE_FALL && $past(s_r.src) != SRC_EXT
        |-> $past(x < lvl_cnt) && $past(s_r.arm_f))
        else $error("falling trigger without downward crossing");

    level_range_a: assert property (
        s_r.level <= LW'(LEVEL_MAX) && s_r.level >= LW'(-LEVEL_MAX))
        else $error("trigger level beyond 100 percent");

    hyst_rearm_a: assert property (
        (s_r.src != SRC_EXT) && I_SAMPLE_VALID && !(I_WR && I_ADDR == ADDR_CTRL)
        && (x < lvl_cnt - hyst) |=> s_r.arm_r)
        else $error("rising arm not set below hysteresis band");

    fall_rearm_a: assert property (
        (s_r.src != SRC_EXT) && I_SAMPLE_VALID && (x > lvl_cnt + hyst) |=> s_r.arm_f)
        else $error("falling arm not set above hysteresis band");

    both_cross_a: assert property (
        O_TRIG && $past(s_r.slope) == SLOPE_BOTH && $past(s_r.src) != SRC_EXT
        |-> $past(s_r.arm_r && x > lvl_cnt) || $past(s_r.arm_f && x < lvl_cnt))
        else $error("both-slope trigger without a crossing");

    integ_no_trig_a: assert property (
        I_INTEG_ACTIVE |=> !O_TRIG && !O_ALIGNED)
        else $error("trigger during integration");

    auto_timeout_c: cover property (
        (s_r.st == ST_WAIT) && !s_r.mode_norm ##1 O_UPDATE && !O_ALIGNED);
    aligned_update_c: cover property (O_UPDATE && O_ALIGNED);
    ext_trigger_c: cover property ((s_r.src == SRC_EXT) && O_TRIG);
    integ_update_c: cover property (I_INTEG_ACTIVE && O_UPDATE);
    both_slope_c: cover property ((s_r.slope == SLOPE_BOTH) && O_TRIG);
endmodule : wtvs_top

// >>> tb/wtvs_src_model.sv
// Model of the sampled voltage/current channels and the external TTL trigger input
`timescale 1ns/1ns
module wtvs_src_model (
    input wire logic i_clock,
    output logic o_valid,
    output logic [wtvs_pkg::NCH*wtvs_pkg::SW-1:0] o_data,
    output logic o_ext
);
    import wtvs_pkg::*;
    logic req = 1'b0;
    logic signed [SW-1:0] val = '0;
    initial begin
        o_valid = 1'b0;
        o_data = '0;
        o_ext = 1'b0;
    end
    // Between samples the data toggles, so stale values never pass for a fresh sample
    always @(posedge i_clock) begin
        o_valid <= req;
        o_data <= req ? {NCH{val}} : ~o_data;
    end
    task automatic send(input logic signed [SW-1:0] v);
        @(negedge i_clock);
        val = v;
        req = 1'b1;
        @(posedge i_clock);
        #1 req = 1'b0;
    endtask : send
    // Caller holds each level at least EXT_PW_CYC cycles, the minimum TTL pulse width
    task automatic ext_set(input logic lvl);
        @(posedge i_clock);
        o_ext <= lvl;
    endtask : ext_set
endmodule : wtvs_src_model

// >>> tb/tb.sv
// Self-checking bench for the waveform trigger and vertical scale block
`timescale 1ns/1ns
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD %s exp %0h got %0h", n, e, a); end end
module tb;
    import wtvs_pkg::*;
    localparam int TO = 64;
    logic clk, srst, wr, rd, integ, tick, ext, sv;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, r;
    logic [3:0] elem;
    logic [2:0] view;
    logic [NCH*SW-1:0] sd;
    logic trig, upd, alg;
    logic [15:0] vz;
    logic signed [SW-1:0] voff;
    int n_errors = 0, cmp_count = 0, n_trig = 0, n_upd = 0, n_alg = 0, cyc = 0, n;

    wtvs_src_model m (.i_clock(clk), .o_valid(sv), .o_data(sd), .o_ext(ext));
    wtvs_top #(.TIMEOUT_CYCLES(TO)) uut (.I_CLOCK(clk), .I_SRST(srst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ELEM_PRESENT(elem),
        .I_INTEG_ACTIVE(integ), .I_INTERVAL_TICK(tick), .I_SAMPLE_VALID(sv),
        .I_SAMPLE_DATA(sd), .I_EXT_CLK(ext), .I_VIEW_CH(view), .O_TRIG(trig),
        .O_UPDATE(upd), .O_ALIGNED(alg), .O_VZOOM(vz), .O_VOFFSET(voff));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Pulse counters; the ceiling cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (trig === 1'b1) n_trig++;
        if (upd === 1'b1) n_upd++;
        if (upd === 1'b1 && alg === 1'b1) n_alg++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_t
    task automatic rd_t(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask : rd_t
    task automatic ctrl(input logic md, input logic [1:0] sl, input logic [3:0] src,
                        input logic cf6);
        wr_t(ADDR_CTRL, {24'h0, cf6, src, sl, md});
    endtask : ctrl
    task automatic start_wait();
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        #1 n_trig = 0;
        n_upd = 0;
        n_alg = 0;
    endtask : start_wait
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic t_regs();
        rd_t(ADDR_CTRL);
        `CHK("ctrl reset", 32'h0, r)
        rd_t(8'h40);
        `CHK("chan0 reset", 32'h7, r)
        rd_t(8'h20);
        `CHK("unmapped", 32'h0, r)
        wr_t(ADDR_LEVEL, 32'd1500);
        rd_t(ADDR_LEVEL);
        `CHK("level max", 32'd1000, r)
        wr_t(ADDR_LEVEL, -32'sd1001);
        rd_t(ADDR_LEVEL);
        `CHK("level min", 32'hfffffc18, r)
    endtask : t_regs

    // Only installed channels or the external input are accepted as source
    task automatic t_src();
        @(posedge clk);
        elem <= 4'h1;
        ctrl(1'b1, SLOPE_RISE, 4'h2, 1'b0);
        rd_t(ADDR_CTRL);
        `CHK("src absent", 32'h1, r)
        ctrl(1'b1, SLOPE_RISE, 4'h1, 1'b0);
        rd_t(ADDR_CTRL);
        `CHK("src ch1", 32'h9, r)
        ctrl(1'b1, SLOPE_RISE, SRC_EXT, 1'b0);
        ctrl(1'b1, SLOPE_RISE, 4'h9, 1'b0);
        rd_t(ADDR_CTRL);
        `CHK("src ext kept", 32'h41, r)
        @(posedge clk);
        elem <= 4'hf;
    endtask : t_src

    // Level 25 % at crest 3 is code 6143, band 491 below it must be left first
    task automatic t_rise();
        ctrl(1'b1, SLOPE_RISE, 4'h0, 1'b0);
        wr_t(ADDR_LEVEL, 32'd250);
        start_wait();
        m.send(18'sd5652);
        m.send(18'sd6144);
        m.send(18'sd5651);
        m.send(18'sd6143);
        settle();
        `CHK("rise early", 0, n_trig)
        m.send(18'sd6144);
        settle();
        `CHK("rise trig", 1, n_trig)
        `CHK("rise upd", 1, n_alg)
    endtask : t_rise

    // Level -25 % at crest 6 is code -12288 with a band of 1966
    task automatic t_fall();
        ctrl(1'b1, SLOPE_FALL, 4'h0, 1'b1);
        wr_t(ADDR_LEVEL, -32'sd250);
        start_wait();
        m.send(-18'sd10322);
        m.send(-18'sd12400);
        settle();
        `CHK("fall early", 0, n_trig)
        m.send(-18'sd10321);
        m.send(-18'sd12400);
        settle();
        `CHK("fall trig", 1, n_alg)
    endtask : t_fall

    task automatic t_both();
        ctrl(1'b1, SLOPE_BOTH, 4'h0, 1'b0);
        wr_t(ADDR_LEVEL, 32'd0);
        start_wait();
        m.send(18'sd492);
        m.send(-18'sd1);
        m.send(-18'sd492);
        m.send(18'sd1);
        settle();
        `CHK("both trig", 2, n_trig)
        `CHK("both upd", 1, n_upd)
    endtask : t_both

    // Normal mode never updates on its own outside integration; auto updates at timeout, unaligned
    task automatic t_modes();
        ctrl(1'b1, SLOPE_RISE, 4'h0, 1'b0);
        start_wait();
        repeat (TO + 20) @(posedge clk);
        #1;
        `CHK("normal idle", 0, n_upd)
        rd_t(ADDR_STATUS);
        `CHK("status wait", 32'hf3, r)
        ctrl(1'b0, SLOPE_RISE, 4'h0, 1'b0);
        settle();
        start_wait();
        n = 0;
        while (upd !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK("timeout cycles", TO, n)
        `CHK("timeout unaligned", 1'b0, alg)
    endtask : t_modes

    // External source ignores the level; edge must show within 1 us plus one clock cycle
    task automatic t_ext();
        ctrl(1'b0, SLOPE_RISE, SRC_EXT, 1'b0);
        wr_t(ADDR_LEVEL, 32'd1000);
        start_wait();
        m.ext_set(1'b1);
        n = 0;
        while (n_trig == 0 && n < EXT_PW_CYC + 1) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK("ext seen", 1, n_trig)
        `CHK("ext aligned", 1, n_alg)
        repeat (EXT_PW_CYC) @(posedge clk);
        m.ext_set(1'b0);
        repeat (EXT_PW_CYC) @(posedge clk);
        #1;
        `CHK("ext fall ignored", 1, n_trig)
    endtask : t_ext

    task automatic t_integ();
        @(posedge clk);
        integ <= 1'b1;
        ctrl(1'b1, SLOPE_RISE, 4'h0, 1'b0);
        wr_t(ADDR_LEVEL, 32'd0);
        start_wait();
        settle();
        `CHK("integ upd", 1, n_upd)
        `CHK("integ unaligned", 0, n_alg)
        m.send(-18'sd600);
        m.send(18'sd600);
        settle();
        `CHK("integ no trig", 0, n_trig)
        @(posedge clk);
        integ <= 1'b0;
    endtask : t_integ

    // Position stays on crest-3 full scale whatever the zoom
    task automatic t_vert();
        settle();
        `CHK("zoom unity", 16'h0100, vz)
        @(posedge clk);
        view <= 3'h3;
        wr_t(8'h4c, {6'h0, 18'h1fd4f, 3'h0, 5'd31});
        rd_t(8'h4c);
        `CHK("pos clamp", {18'h1fbd0, 3'h0, 5'd31}, r[25:0])
        wr_t(8'h4c, {6'h0, 18'd50000, 3'h0, 5'd31});
        settle();
        `CHK("zoom max", 16'h6400, vz)
        `CHK("offset", 18'sd12288, voff)
    endtask : t_vert

    initial begin
        srst <= 1'b1;
        wr <= 1'b0;
        rd <= 1'b0;
        integ <= 1'b0;
        tick <= 1'b0;
        addr <= 8'h00;
        wdata <= 32'h0;
        elem <= 4'hf;
        view <= 3'h0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_src();
        t_rise();
        t_fall();
        t_both();
        t_modes();
        t_ext();
        t_integ();
        t_vert();
        finish_test();
    end
endmodule : tb
